// ==== fspc_pkg.sv ====
// Constants, types and decode helpers for the flash self-programming
// controller. Assumes a 50 MHz system clock and a CPU-side register port.
`default_nettype none

package fspc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register port
    localparam int unsigned REG_ADDR_W    = 4;
    localparam logic [3:0]  OFS_CTRL      = 4'h0;
    localparam logic [3:0]  OFS_KEY       = 4'h1;
    localparam logic [3:0]  OFS_PAGE      = 4'h2;

    ////////////////////////////////////////////////////////////////////////
    // Control register fields and reset values
    localparam int unsigned CTRL_START_BIT  = 15;
    localparam int unsigned CTRL_PERMIT_BIT = 14;
    localparam int unsigned CTRL_FAULT_BIT  = 13;
    localparam int unsigned CTRL_ERASE_BIT  = 6;
    localparam int unsigned CTRL_OPC_LSB    = 0;
    localparam int unsigned CTRL_OPC_W      = 4;
    localparam logic        CTRL_BIT_RESET  = 1'b0;
    localparam logic [3:0]  OPC_RESET       = 4'h0;
    localparam logic [7:0]  PAGE_RESET      = 8'h00;
    localparam int unsigned PAGE_CFG_BIT    = 7;

    ////////////////////////////////////////////////////////////////////////
    // Unlock key values
    localparam logic [7:0]  KEY_FIRST     = 8'h55;
    localparam logic [7:0]  KEY_SECOND    = 8'haa;

    ////////////////////////////////////////////////////////////////////////
    // Array geometry; addresses step by two per instruction
    localparam int unsigned ROW_WORDS     = 64;
    localparam int unsigned ROW_BYTES     = 192;
    localparam int unsigned PAGE_ROWS     = 8;
    localparam int unsigned PAGE_WORDS    = ROW_WORDS * PAGE_ROWS;
    localparam int unsigned PAGE_BYTES    = ROW_BYTES * PAGE_ROWS;
    localparam int unsigned PM_ADDR_W     = 24;
    localparam int unsigned WORD_W        = 24;
    localparam int unsigned BUF_IDX_W     = $clog2(ROW_WORDS);
    localparam logic [23:0] ROW_MASK      = ~24'(ROW_WORDS * 2 - 1);
    localparam logic [23:0] PAGE_MASK     = ~24'(PAGE_WORDS * 2 - 1);

    ////////////////////////////////////////////////////////////////////////
    // Operation timing
    localparam int unsigned OP_TIME_NS    = 4000000;
    localparam int unsigned CLK_PERIOD_NS = 20;

    ////////////////////////////////////////////////////////////////////////
    // Operation code values
    localparam logic [3:0]  OPC_BULK      = 4'hf;
    localparam logic [3:0]  OPC_GEN_SEG   = 4'hd;
    localparam logic [3:0]  OPC_SEC_SEG   = 4'hc;
    localparam logic [3:0]  OPC_PAGE      = 4'h2;
    localparam logic [3:0]  OPC_CFG       = 4'h0;
    localparam logic [3:0]  OPC_WORD      = 4'h3;
    localparam logic [3:0]  OPC_ROW       = 4'h1;

    typedef enum logic [3:0] {
        OP_NOP        = 4'b0000,
        OP_BULK_ERASE = 4'b0001,
        OP_GSEG_ERASE = 4'b0010,
        OP_SSEG_ERASE = 4'b0011,
        OP_PAGE_ERASE = 4'b0100,
        OP_CFG_ERASE  = 4'b0101,
        OP_WORD_PROG  = 4'b0110,
        OP_ROW_PROG   = 4'b0111,
        OP_CFG_PROG   = 4'b1000,
        OP_BAD        = 4'b1001
    } fspc_op_t;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_RUN  = 1'b1
    } fspc_state_t;

    typedef enum logic [1:0] {
        KEY_IDLE  = 2'b00,
        KEY_ONE   = 2'b01,
        KEY_ARMED = 2'b10
    } fspc_key_t;

    ////////////////////////////////////////////////////////////////////////
    // Erase flag plus code to operation
    function automatic fspc_op_t fspc_decode_op(input logic       erase,
                                                input logic [3:0] code);
        fspc_op_t op;
        op = OP_BAD;
        if (erase) begin
            case (code)
                OPC_BULK:         op = OP_BULK_ERASE;
                OPC_GEN_SEG:      op = OP_GSEG_ERASE;
                OPC_SEC_SEG:      op = OP_SSEG_ERASE;
                OPC_PAGE:         op = OP_PAGE_ERASE;
                OPC_CFG:          op = OP_CFG_ERASE;
                OPC_WORD,
                OPC_ROW:          op = OP_NOP;
                default:          op = OP_BAD;
            endcase
        end else begin
            case (code)
                OPC_WORD:         op = OP_WORD_PROG;
                OPC_ROW:          op = OP_ROW_PROG;
                OPC_CFG:          op = OP_CFG_PROG;
                OPC_BULK,
                OPC_GEN_SEG,
                OPC_SEC_SEG,
                OPC_PAGE:         op = OP_NOP;
                default:          op = OP_BAD;
            endcase
        end
        return op;
    endfunction : fspc_decode_op

endpackage : fspc_pkg

`default_nettype wire

// ==== fspc_hold_buf.sv ====
// Holding buffer for one row of program words, with per-byte lane writes.
// Assumes a single writer and one registered read port for the array.
`default_nettype none

module fspc_hold_buf #(
    parameter int unsigned DEPTH = 64,
    parameter int unsigned WIDTH = 24,
    parameter int unsigned IDX_W = $clog2(DEPTH),
    parameter int unsigned LANES = WIDTH / 8
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             wr_en,
    input  wire logic [IDX_W-1:0] wr_idx,
    input  wire logic [LANES-1:0] wr_lane,
    input  wire logic [WIDTH-1:0] wr_data,
    input  wire logic [IDX_W-1:0] rd_idx,
    output logic      [WIDTH-1:0] rd_data
);

    logic [WIDTH-1:0] mem [DEPTH];

    ////////////////////////////////////////////////////////////////////////
    // Lane writes
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= '0;
            end
        end else if (wr_en) begin
            for (int l = 0; l < LANES; l++) begin
                if (wr_lane[l]) begin
                    mem[wr_idx][l*8 +: 8] <= wr_data[l*8 +: 8];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registered read
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rd_data <= '0;
        end else begin
            rd_data <= mem[rd_idx];
        end
    end

endmodule : fspc_hold_buf

`default_nettype wire

// ==== fspc_flash_ctrl.sv ====
// Flash self-programming controller: table access, unlock, timed operation.
// Assumes the CPU honours cpu_stall and the array answers reads in-cycle.
//
// The implementer's own choices: the placing of the registers and strobed register access.
`default_nettype none

module fspc_flash_ctrl
    import fspc_pkg::*;
#(
    parameter int unsigned OP_CYCLES = OP_TIME_NS / CLK_PERIOD_NS,
    parameter int unsigned CNT_W     = $clog2(OP_CYCLES + 1)
) (
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire logic [REG_ADDR_W-1:0] reg_addr,
    input  wire logic [15:0]           reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output logic      [15:0]           reg_rdata,
    input  wire logic                  tbl_wr,
    input  wire logic                  tbl_rd,
    input  wire logic                  tbl_high,
    input  wire logic                  tbl_byte,
    input  wire logic [15:0]           tbl_ea,
    input  wire logic [15:0]           tbl_wdata,
    output logic      [15:0]           tbl_rdata,
    output logic                       tbl_rvalid,
    output logic                       cpu_stall,
    output logic      [PM_ADDR_W-1:0]  arr_addr,
    output logic                       arr_cfg,
    input  wire logic [WORD_W-1:0]     arr_rdata,
    output logic                       nvm_go,
    output logic                       nvm_done,
    output fspc_op_t                   nvm_op,
    output logic      [PM_ADDR_W-1:0]  nvm_addr,
    input  wire logic [BUF_IDX_W-1:0]  buf_idx,
    output logic      [WORD_W-1:0]     buf_data
);

    ////////////////////////////////////////////////////////////////////////
    // State
    fspc_state_t              state;
    fspc_key_t                key_state;
    logic                     start;
    logic                     permit;
    logic                     fault;
    logic                     erase;
    logic [CTRL_OPC_W-1:0]    opc;
    logic [7:0]               page;
    logic [CNT_W-1:0]         op_cnt;
    logic [PM_ADDR_W-1:0]     tw_addr;
    logic                     rd_pend;
    logic                     rd_high;
    logic                     rd_byte;
    logic                     rd_sel;

    ////////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic [15:0] fmt_read(input logic        high,
                                             input logic        bsel,
                                             input logic        sel,
                                             input logic [23:0] word);
        logic [15:0] r;
        r = 16'h0000;
        if (high) begin
            r = (bsel && sel) ? 16'h0000 : {8'h00, word[23:16]};
        end else if (bsel) begin
            r = {8'h00, sel ? word[15:8] : word[7:0]};
        end else begin
            r = word[15:0];
        end
        return r;
    endfunction : fmt_read

    function automatic logic [23:0] align_addr(input fspc_op_t    op,
                                               input logic [23:0] a);
        logic [23:0] r;
        r = a;
        if (op == OP_PAGE_ERASE) begin
            r = a & PAGE_MASK;
        end else if (op == OP_ROW_PROG) begin
            r = a & ROW_MASK;
        end
        return r;
    endfunction : align_addr

    ////////////////////////////////////////////////////////////////////////
    // Register decode
    wire                  busy     = (state == ST_RUN);
    wire                  wr_ctrl  = reg_wr && !busy && reg_addr == OFS_CTRL;
    wire                  wr_key   = reg_wr && !busy && reg_addr == OFS_KEY;
    wire                  wr_page  = reg_wr && !busy && reg_addr == OFS_PAGE;
    wire                  w_start  = wr_ctrl && reg_wdata[CTRL_START_BIT];
    wire                  w_permit = reg_wdata[CTRL_PERMIT_BIT];
    wire                  w_erase  = reg_wdata[CTRL_ERASE_BIT];
    wire [CTRL_OPC_W-1:0] w_opc    = reg_wdata[CTRL_OPC_LSB +: CTRL_OPC_W];
    wire fspc_op_t        w_op     = fspc_decode_op(w_erase, w_opc);
    wire                  armed    = (key_state == KEY_ARMED);
    wire                  op_real  = (w_op != OP_NOP) && (w_op != OP_BAD);
    wire                  launch   = w_start && armed && w_permit && op_real;
    wire                  bad_seq  = w_start && (!armed || w_op == OP_BAD);
    wire                  op_last  = busy &&
                                     op_cnt == CNT_W'(OP_CYCLES - 1);
    wire [15:0]           ctrl_val = {start, permit, fault, 6'h00, erase,
                                      2'b00, opc};
    wire [15:0]           rd_mux   = (reg_addr == OFS_CTRL) ? ctrl_val :
                                     (reg_addr == OFS_PAGE) ? {8'h00, page} :
                                     16'h0000;

    ////////////////////////////////////////////////////////////////////////
    // Table access decode
    wire [PM_ADDR_W-1:0]  tbl_addr = {page, tbl_ea};
    wire                  t_sel    = tbl_ea[0];
    wire                  t_wr     = tbl_wr && !busy;
    wire                  t_rd     = tbl_rd && !busy;
    wire [2:0]            t_lane   = tbl_high ? ((tbl_byte && t_sel) ?
                                                 3'b000 : 3'b100) :
                                    tbl_byte ? (t_sel ? 3'b010 : 3'b001) :
                                    3'b011;
    wire [WORD_W-1:0]     t_data   = {tbl_wdata[7:0], tbl_byte ?
                                     {2{tbl_wdata[7:0]}} : tbl_wdata};
    wire [BUF_IDX_W-1:0]  t_idx    = tbl_ea[BUF_IDX_W:1];
    wire                  next_fault = bad_seq ? 1'b1 :
                                       op_last ? 1'b0 :
                                       wr_ctrl ? reg_wdata[CTRL_FAULT_BIT] :
                                       fault;
    wire fspc_state_t     next_state = launch  ? ST_RUN :
                                       op_last ? ST_IDLE : state;

    ////////////////////////////////////////////////////////////////////////
    // Holding buffer
    fspc_hold_buf #(
        .DEPTH   (ROW_WORDS),
        .WIDTH   (WORD_W),
        .IDX_W   (BUF_IDX_W),
        .LANES   (3)
    ) u_hold_buf (
        .clk     (clk),
        .rst_n   (rst_n),
        .wr_en   (t_wr),
        .wr_idx  (t_idx),
        .wr_lane (t_lane),
        .wr_data (t_data),
        .rd_idx  (buf_idx),
        .rd_data (buf_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // Control register, reset by power-on reset only
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            permit <= CTRL_BIT_RESET;
            erase  <= CTRL_BIT_RESET;
            opc    <= OPC_RESET;
            start  <= CTRL_BIT_RESET;
            fault  <= CTRL_BIT_RESET;
            page   <= PAGE_RESET;
        end else begin
            if (wr_ctrl) begin
                permit <= w_permit;
                erase  <= w_erase;
                opc    <= w_opc;
            end
            if (wr_page) begin
                page <= reg_wdata[7:0];
            end
            if (launch) begin
                start <= 1'b1;
            end else if (op_last) begin
                start <= 1'b0;
            end
            fault <= next_fault;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Unlock sequence tracker
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            key_state <= KEY_IDLE;
        end else if (wr_key && reg_wdata[7:0] == KEY_FIRST) begin
            key_state <= KEY_ONE;
        end else if (wr_key && key_state == KEY_ONE &&
                     reg_wdata[7:0] == KEY_SECOND) begin
            key_state <= KEY_ARMED;
        end else if (reg_wr) begin
            key_state <= KEY_IDLE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Self-timed operation
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state     <= ST_IDLE;
            cpu_stall <= 1'b0;
            op_cnt    <= '0;
            nvm_go    <= 1'b0;
            nvm_done  <= 1'b0;
            nvm_op    <= OP_NOP;
            nvm_addr  <= '0;
        end else begin
            state     <= next_state;
            cpu_stall <= (next_state == ST_RUN);
            op_cnt    <= launch ? '0 : busy ? op_cnt + 1'b1 : op_cnt;
            nvm_go    <= launch;
            nvm_done  <= op_last;
            if (launch) begin
                nvm_op   <= w_op;
                nvm_addr <= align_addr(w_op, tw_addr);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Table access path
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tw_addr    <= '0;
            arr_addr   <= '0;
            arr_cfg    <= 1'b0;
            rd_pend    <= 1'b0;
            rd_high    <= 1'b0;
            rd_byte    <= 1'b0;
            rd_sel     <= 1'b0;
            tbl_rdata  <= 16'h0000;
            tbl_rvalid <= 1'b0;
        end else begin
            if (t_wr) begin
                tw_addr <= tbl_addr;
            end
            if (t_rd) begin
                arr_addr <= tbl_addr;
                arr_cfg  <= page[PAGE_CFG_BIT];
                rd_high  <= tbl_high;
                rd_byte  <= tbl_byte;
                rd_sel   <= t_sel;
            end
            rd_pend    <= t_rd;
            tbl_rvalid <= rd_pend;
            tbl_rdata  <= rd_pend ?
                          fmt_read(rd_high, rd_byte, rd_sel, arr_rdata) :
                          16'h0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register read port
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            reg_rdata <= 16'h0000;
        end else begin
            reg_rdata <= reg_rd ? rd_mux : 16'h0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_unlock_start;
        (wr_key && reg_wdata[7:0] == KEY_FIRST) ##1
        (wr_key && reg_wdata[7:0] == KEY_SECOND) ##1 w_start;
    endsequence

    sequence s_run_end;
        $fell(cpu_stall) ##0 nvm_done;
    endsequence

    property p_unlock_launch;
        s_unlock_start ##0 (w_permit && op_real) |=> cpu_stall && nvm_go;
    endproperty
    a_unlock_launch: assert property (p_unlock_launch)
        else $error("unlocked start did not launch");

    property p_nokey_fault;
        (w_start && key_state != KEY_ARMED) |=> fault && !cpu_stall;
    endproperty
    a_nokey_fault: assert property (p_nokey_fault)
        else $error("start without unlock was not refused");

    property p_permit;
        (w_start && !w_permit) |=> !cpu_stall && !nvm_go;
    endproperty
    a_permit: assert property (p_permit)
        else $error("operation ran with permit clear");

    property p_op_length;
        $fell(cpu_stall) |-> $past(op_cnt) == CNT_W'(OP_CYCLES - 1);
    endproperty
    a_op_length: assert property (p_op_length)
        else $error("operation length wrong");

    property p_stall_hold;
        nvm_go |-> cpu_stall [*8];
    endproperty
    a_stall_hold: assert property (p_stall_hold)
        else $error("stall dropped early");

    property p_start_clears;
        s_run_end |-> !start && !fault;
    endproperty
    a_start_clears: assert property (p_start_clears)
        else $error("start or fault not cleared at end");

    property p_reserved;
        (w_start && (w_opc == 4'he || w_opc == 4'hb)) |=> fault && !nvm_go;
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved code not faulted");

    property p_row_align;
        (nvm_go && nvm_op == OP_ROW_PROG) |-> nvm_addr[6:0] == 7'h00;
    endproperty
    a_row_align: assert property (p_row_align)
        else $error("row address misaligned");

    property p_page_align;
        (nvm_go && nvm_op == OP_PAGE_ERASE) |-> nvm_addr[9:0] == 10'h000;
    endproperty
    a_page_align: assert property (p_page_align)
        else $error("page address misaligned");

    property p_zero_fields;
        (reg_rd && reg_addr == OFS_CTRL) |=>
            reg_rdata[12:7] == 6'h00 && reg_rdata[5:4] == 2'b00;
    endproperty
    a_zero_fields: assert property (p_zero_fields)
        else $error("unimplemented control bits not zero");

    property p_key_zero;
        (reg_rd && reg_addr == OFS_KEY) |=> reg_rdata == 16'h0000;
    endproperty
    a_key_zero: assert property (p_key_zero)
        else $error("key register read not zero");

    property p_read_latency;
        t_rd |-> (!tbl_rvalid || $past(t_rd, 2)) ##2 tbl_rvalid;
    endproperty
    a_read_latency: assert property (p_read_latency)
        else $error("table read answer late");

    property p_high_phantom;
        (t_rd && tbl_high) |-> ##2 tbl_rdata[15:8] == 8'h00;
    endproperty
    a_high_phantom: assert property (p_high_phantom)
        else $error("high table read phantom byte not zero");

endmodule : fspc_flash_ctrl

`default_nettype wire

// ==== fspc_array_model.sv ====
// Array model: table read data and a running mirror of the holding buffer.
// Assumes the controller clock and reset.
`default_nettype none
module fspc_array_model
    import fspc_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire logic                 tbl_rd,
    input  wire logic [PM_ADDR_W-1:0] arr_addr,
    input  wire logic                 arr_cfg,
    output logic      [WORD_W-1:0]    arr_rdata,
    output logic      [BUF_IDX_W-1:0] buf_idx,
    input  wire logic [WORD_W-1:0]    buf_data
);
    timeunit 1ns;
    timeprecision 1ns;
    logic                 rd_seen;
    logic [BUF_IDX_W-1:0] prev_idx;
    logic [WORD_W-1:0]    row [ROW_WORDS];
    logic [WORD_W-1:0]    word;
    // Content differs per space; stale data inverted
    assign word = {arr_addr[7:0] ^ {8{arr_cfg}}, arr_addr[23:8]};
    assign arr_rdata = rd_seen ? word : ~word;
    always_ff @(posedge clk) begin
        rd_seen <= rst_n & tbl_rd;
        buf_idx <= rst_n ? buf_idx + 6'h01 : 6'h00;
        prev_idx <= buf_idx;
        row[prev_idx] <= buf_data;
    end
endmodule : fspc_array_model
`default_nettype wire

// ==== test_flash_self_program_control.sv ====
// Register, table and operation tests for the controller.
// Assumes the array model as far side and a 50 MHz clock.
`default_nettype none
module test_flash_self_program_control import fspc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int unsigned OPC = 20;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] stb = 4'h0;
    logic [REG_ADDR_W-1:0] reg_addr = '0;
    logic [15:0] reg_wdata = '0, tbl_ea = '0, tbl_wdata = '0;
    logic tbl_high = 1'b0, tbl_byte = 1'b0, arr_cfg, nvm_go, nvm_done;
    logic cpu_stall, tbl_rvalid;
    logic [15:0] reg_rdata, tbl_rdata;
    logic [23:0] arr_addr, nvm_addr, arr_rdata, buf_data, ex;
    logic [5:0] buf_idx;
    fspc_op_t nvm_op;
    wire logic reg_wr, reg_rd, tbl_wr, tbl_rd;
    int err_total = 0, comparisons = 0, cyc = 0, n, k;
    logic [15:0] cv [18] = '{16'hc04f, 16'hc04d, 16'hc04c, 16'hc042,
        16'hc040, 16'hc043, 16'hc041, 16'hc04e, 16'hc003, 16'hc001,
        16'hc000, 16'hc00f, 16'hc00d, 16'hc00c, 16'hc002, 16'hc00b,
        16'hc007, 16'h8001};
    fspc_op_t ev [18] = '{OP_BULK_ERASE, OP_GSEG_ERASE, OP_SSEG_ERASE,
        OP_PAGE_ERASE, OP_CFG_ERASE, OP_NOP, OP_NOP, OP_BAD, OP_WORD_PROG,
        OP_ROW_PROG, OP_CFG_PROG, OP_NOP, OP_NOP, OP_NOP, OP_NOP, OP_BAD,
        OP_BAD, OP_NOP};
    assign {reg_wr, reg_rd, tbl_wr, tbl_rd} = stb;
    always #10 clk = ~clk;
    fspc_flash_ctrl #(.OP_CYCLES(OPC)) fspc_flash_ctrl_i (.clk, .rst_n,
        .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .tbl_wr,
        .tbl_rd, .tbl_high, .tbl_byte, .tbl_ea, .tbl_wdata, .tbl_rdata,
        .tbl_rvalid, .cpu_stall, .arr_addr, .arr_cfg, .arr_rdata, .nvm_go,
        .nvm_done, .nvm_op, .nvm_addr, .buf_idx, .buf_data);
    fspc_array_model fspc_array_model_i (.clk, .rst_n, .tbl_rd, .arr_addr,
        .arr_cfg, .arr_rdata, .buf_idx, .buf_data);
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string s, input logic [23:0] e, g);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", s, e, g);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        stb <= 4'h8;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [15:0] e, string s);
        @(posedge clk);
        reg_addr <= a;
        stb <= 4'h4;
        @(posedge clk);
        stb <= 4'h0;
        #1 chk(s, 24'(e), 24'(reg_rdata));
    endtask : rd
    task automatic tw(input logic h, b, input logic [15:0] ea, d);
        @(posedge clk);
        {tbl_high, tbl_byte, tbl_ea, tbl_wdata} <= {h, b, ea, d};
        stb <= 4'h2;
    endtask : tw
    task automatic tr(input logic h, b, input logic [15:0] ea, e, string s);
        @(posedge clk);
        {tbl_high, tbl_byte, tbl_ea} <= {h, b, ea};
        stb <= 4'h1;
        @(posedge clk);
        stb <= 4'h0;
        @(posedge clk);
        #1 chk(s, 24'(e), 24'(tbl_rdata));
        chk("rvalid", 24'h1, 24'(tbl_rvalid));
    endtask : tr
    task automatic op(input logic [15:0] c, input fspc_op_t e);
        logic launch;
        launch = (e != OP_NOP) && (e != OP_BAD);
        wr(OFS_KEY, 16'(KEY_FIRST));
        wr(OFS_KEY, 16'(KEY_SECOND));
        wr(OFS_CTRL, c);
        @(posedge clk);
        stb <= 4'h0;
        #1 chk("go", 24'(launch), 24'(nvm_go));
        if (launch) begin
            chk("op", 24'(e), 24'(nvm_op));
            chk("stall", 24'h1, 24'(cpu_stall));
            if (e == OP_ROW_PROG) chk("row", 24'h016080, nvm_addr);
            if (e == OP_PAGE_ERASE) chk("pg", 24'h016000, nvm_addr);
            n = 0;
            while (nvm_done !== 1'b1 && n < 100) begin
                @(posedge clk);
                #1 n++;
            end
            chk("cycles", 24'(OPC), 24'(n));
            chk("stall", 24'h0, 24'(cpu_stall));
        end
        ex = 24'((c & 16'h404f) | (e == OP_BAD ? 16'h2000 : 16'h0000));
        rd(OFS_CTRL, ex[15:0], "ctrl");
    endtask : op
    task automatic results();
        $display("mismatches %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : results
    ////////////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        cyc++;
        if (cyc == 8000) begin
            err_total++;
            results();
        end
    end
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        rd(OFS_CTRL, 16'h0000, "ctrl");
        rd(OFS_PAGE, 16'(PAGE_RESET), "page");
        wr(OFS_KEY, 16'hff55);
        rd(OFS_KEY, 16'h0000, "key");
        wr(4'hf, 16'hffff);
        rd(4'hf, 16'h0000, "unmapped");
        wr(OFS_CTRL, 16'h7ff0);
        rd(OFS_CTRL, 16'h6040, "ctrl");
        wr(OFS_CTRL, 16'hc001);
        rd(OFS_CTRL, 16'h6001, "ctrl");
        wr(OFS_PAGE, 16'h0081);
        tr(0, 0, 16'h1234, 16'h8112, "low word");
        chk("addr", 24'h811234, arr_addr);
        chk("cfg", 24'h1, 24'(arr_cfg));
        tr(1, 0, 16'h1234, 16'h00cb, "high word");
        tr(0, 1, 16'h1235, 16'h0081, "low byte");
        tr(1, 1, 16'h1235, 16'h0000, "phantom");
        tr(1, 1, 16'h1234, 16'h00cb, "high byte");
        wr(OFS_PAGE, 16'h0001);
        tr(0, 0, 16'h1234, 16'h0112, "user word");
        chk("cfg", 24'h0, 24'(arr_cfg));
        for (k = 0; k < 64; k++) begin
            tw(0, 0, 16'(16'h6080 + 2 * k), 16'(16'h1000 + k));
            tw(1, 0, 16'(16'h6080 + 2 * k), 16'(16'h0080 + k));
        end
        tw(0, 1, 16'h608b, 16'heeee);
        tw(1, 1, 16'h608d, 16'h00ff);
        tw(1, 1, 16'h608e, 16'h0033);
        tw(0, 0, 16'h60fe, 16'h103f);
        tr(0, 0, 16'h6080, 16'h0160, "array kept");
        for (k = 0; k < 18; k++) op(cv[k], ev[k]);
        repeat (70) @(posedge clk);
        for (k = 0; k < 64; k++) begin
            ex = {8'(8'h80 + k), 16'(16'h1000 + k)};
            if (k == 5) ex[15:8] = 8'hee;
            if (k == 7) ex[23:16] = 8'h33;
            chk("buffer", ex, fspc_array_model_i.row[k]);
        end
        results();
    end
endmodule : test_flash_self_program_control
`default_nettype wire
